// [design/htr_pkg.sv]
// Purpose: Shared constants and types of the sensor register block
// Assumes: Byte-wide registers behind a two-wire target port
// Notes: Offsets are register pointer values
package htr_pkg;
  localparam logic [6:0] TARGET_BUS_ADDRESS = 7'h7f;
  localparam logic BUS_IDLE_LEVEL = 1'b1;

  localparam logic [7:0] REG_SOFT_RESET = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_FAULT = 8'h03;
  localparam logic [7:0] REG_HUM_LOW = 8'h04;
  localparam logic [7:0] REG_HUM_HIGH = 8'h05;
  localparam logic [7:0] REG_TEMP_LOW = 8'h06;
  localparam logic [7:0] REG_TEMP_HIGH = 8'h07;
  localparam logic [7:0] REG_CAP_LOW = 8'h0a;
  localparam logic [7:0] REG_CAP_HIGH = 8'h0b;

  localparam int SOFT_RESET_BIT = 0;
  localparam int MODE_FIELD_LSB = 6;
  localparam int HUM_AVG_LSB = 3;
  localparam int TEMP_AVG_BIT = 2;
  localparam int MANUAL_BIT = 0;
  localparam int FAULT_BIT = 0;
  localparam int RW_BIT = 0;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  localparam logic [1:0] MODE_FIELD_RESET = 2'h0;
  localparam logic [2:0] HUM_AVG_RESET = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Averaging as log2 of sample count
  localparam logic [1:0] HUM_AVG_1 = 2'h0;
  localparam logic [1:0] HUM_AVG_2 = 2'h1;
  localparam logic [1:0] HUM_AVG_4 = 2'h2;
  localparam logic [1:0] HUM_AVG_8 = 2'h3;
  localparam logic [2:0] TEMP_AVG_8 = 3'h3;
  localparam logic [2:0] TEMP_AVG_16 = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_W = 3'b010,
    ST_RX = 3'b011,
    ST_ACK_R = 3'b100,
    ST_TX = 3'b101,
    ST_TXACK = 3'b110
  } htr_state_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [9:0] humidity_result;
    logic [10:0] temperature_result;
    logic [15:0] capacitance;
  } htr_result_t;

  typedef struct packed {
    logic run;
    logic [1:0] hum_avg_log2;
    logic [2:0] temp_avg_log2;
  } htr_ctrl_t;

  typedef struct packed {
    logic sleep;
    logic regulator_on;
    logic oscillator_on;
    logic otp_read_en;
    logic bus_on;
  } htr_power_t;
endpackage

// [design/htr_sensor_regs.sv]
// Purpose: Two-wire target and control/result registers of the sensor
// Assumes: Bus clock far slower than clk_in; results arrive as a pulse
// Notes: Data line is open drain, low while sda_oe_out is high
`timescale 1ns/100ps
module htr_sensor_regs (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic chip_enable_in,
  input wire logic power_control_variant_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire htr_pkg::htr_result_t result_in,
  output htr_pkg::htr_ctrl_t ctrl_out,
  output htr_pkg::htr_power_t power_out,
  output logic soft_reset_out
);
  import htr_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  logic ce_lvl, var_lvl, scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall;
  logic sleep, start_cond, stop_cond, wr_stb;
  logic [7:0] rd_data;
  htr_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic first_q, first_d, oe_q, oe_d;
  logic [1:0] mfield_q, mfield_d;
  logic [2:0] hum_avg_q, hum_avg_d;
  logic temperature_averaging_bit_q, temperature_averaging_bit_d;
  logic manual_measurement_bit_q, manual_measurement_bit_d;
  logic fault_q, fault_d, srst_q, srst_d;
  logic [9:0] humidity_result_q, humidity_result_d;
  logic [10:0] temperature_result_q, temperature_result_d;
  logic [15:0] cap_q, cap_d;

  htr_sync u_ce (.clk_in(clk_in), .arst_n_in(arst_n_in), .async_in(chip_enable_in),
    .level_out(ce_lvl), .rise_out(), .fall_out());
  htr_sync u_var (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .async_in(power_control_variant_in), .level_out(var_lvl), .rise_out(), .fall_out());
  htr_sync #(.IDLE_LEVEL(BUS_IDLE_LEVEL)) u_scl (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .async_in(scl_in), .level_out(scl_lvl), .rise_out(scl_rise), .fall_out(scl_fall));
  htr_sync #(.IDLE_LEVEL(BUS_IDLE_LEVEL)) u_sda (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .async_in(sda_in), .level_out(sda_lvl), .rise_out(sda_rise), .fall_out(sda_fall));

  assign sleep = ~ce_lvl & ~var_lvl;
  assign power_out.sleep = sleep;
  assign power_out.regulator_on = ~sleep;
  assign power_out.oscillator_on = ~sleep;
  assign power_out.otp_read_en = ~sleep;
  assign power_out.bus_on = ~sleep;
  assign start_cond = sda_fall & scl_lvl;
  assign stop_cond = sda_rise & scl_lvl;

  // Read mux, unmapped and reserved bits read zero
  always_comb begin
    rd_data = READ_ZERO;
    case (ptr_q)
      REG_MODE: begin
        rd_data[MODE_FIELD_LSB +: 2] = mfield_q;
        rd_data[HUM_AVG_LSB +: 3] = hum_avg_q;
        rd_data[TEMP_AVG_BIT] = temperature_averaging_bit_q;
        rd_data[MANUAL_BIT] = manual_measurement_bit_q;
      end
      REG_FAULT: rd_data[FAULT_BIT] = fault_q;
      REG_HUM_LOW: rd_data = humidity_result_q[7:0];
      REG_HUM_HIGH: rd_data[1:0] = humidity_result_q[9:8];
      REG_TEMP_LOW: rd_data = temperature_result_q[7:0];
      REG_TEMP_HIGH: rd_data[2:0] = temperature_result_q[10:8];
      REG_CAP_LOW: rd_data = cap_q[7:0];
      REG_CAP_HIGH: rd_data = cap_q[15:8];
      default: rd_data = READ_ZERO;
    endcase
  end

  // Bus engine
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    first_d = first_q;
    oe_d = oe_q;
    wr_stb = 1'b0;
    if (sleep) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (start_cond) begin
      st_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_cond) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: st_d = ST_IDLE;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_lvl};
            cnt_d = 4'(cnt_q + 4'h1);
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = 4'h0;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:1] != TARGET_BUS_ADDRESS) begin
                st_d = ST_IDLE;
              end else if (sh_q[RW_BIT]) begin
                oe_d = 1'b1;
                st_d = ST_ACK_R;
              end else begin
                oe_d = 1'b1;
                st_d = ST_ACK_W;
                first_d = 1'b1;
              end
            end else begin
              oe_d = 1'b1;
              st_d = ST_ACK_W;
              if (first_q) begin
                ptr_d = sh_q;
                first_d = 1'b0;
              end else begin
                wr_stb = 1'b1;
                ptr_d = 8'(ptr_q + 8'h01);
              end
            end
          end
        end
        ST_ACK_W: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = ST_RX;
            cnt_d = 4'h0;
          end
        end
        ST_ACK_R: begin
          if (scl_fall) begin
            sh_d = rd_data;
            oe_d = ~rd_data[7];
            st_d = ST_TX;
            cnt_d = 4'h0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == LAST_BIT) begin
              oe_d = 1'b0;
              st_d = ST_TXACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
              cnt_d = 4'(cnt_q + 4'h1);
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            ptr_d = 8'(ptr_q + 8'h01);
            if (sda_lvl) begin
              st_d = ST_IDLE;
            end
          end else if (scl_fall) begin
            sh_d = rd_data;
            oe_d = ~rd_data[7];
            st_d = ST_TX;
            cnt_d = 4'h0;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      first_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      first_q <= first_d;
      oe_q <= oe_d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;

  // Register file
  always_comb begin
    mfield_d = mfield_q;
    hum_avg_d = hum_avg_q;
    temperature_averaging_bit_d = temperature_averaging_bit_q;
    manual_measurement_bit_d = manual_measurement_bit_q;
    fault_d = fault_q;
    srst_d = 1'b0;
    humidity_result_d = humidity_result_q;
    temperature_result_d = temperature_result_q;
    cap_d = cap_q;
    if (result_in.valid) begin
      humidity_result_d = result_in.humidity_result;
      temperature_result_d = result_in.temperature_result;
      cap_d = result_in.capacitance;
      manual_measurement_bit_d = 1'b0;
    end
    if (wr_stb) begin
      case (ptr_q)
        REG_SOFT_RESET: begin
          if (sh_q[SOFT_RESET_BIT]) begin
            srst_d = 1'b1;
            mfield_d = MODE_FIELD_RESET;
            hum_avg_d = HUM_AVG_RESET;
            temperature_averaging_bit_d = 1'b0;
            manual_measurement_bit_d = 1'b0;
            fault_d = 1'b0;
          end
        end
        REG_MODE: begin
          mfield_d = sh_q[MODE_FIELD_LSB +: 2];
          hum_avg_d = sh_q[HUM_AVG_LSB +: 3];
          temperature_averaging_bit_d = sh_q[TEMP_AVG_BIT];
          manual_measurement_bit_d = sh_q[MANUAL_BIT];
        end
        REG_FAULT: begin
          if (sh_q[FAULT_BIT]) begin
            fault_d = 1'b0;
          end
        end
        default: fault_d = fault_d;
      endcase
    end
    if (result_in.fault) begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mfield_q <= MODE_FIELD_RESET;
      hum_avg_q <= HUM_AVG_RESET;
      temperature_averaging_bit_q <= 1'b0;
      manual_measurement_bit_q <= 1'b0;
      fault_q <= 1'b0;
      srst_q <= 1'b0;
      humidity_result_q <= 10'h000;
      temperature_result_q <= 11'h000;
      cap_q <= 16'h0000;
    end else begin
      mfield_q <= mfield_d;
      hum_avg_q <= hum_avg_d;
      temperature_averaging_bit_q <= temperature_averaging_bit_d;
      manual_measurement_bit_q <= manual_measurement_bit_d;
      fault_q <= fault_d;
      srst_q <= srst_d;
      humidity_result_q <= humidity_result_d;
      temperature_result_q <= temperature_result_d;
      cap_q <= cap_d;
    end
  end

  assign soft_reset_out = srst_q;
  assign ctrl_out.run = manual_measurement_bit_q & ~sleep;
  assign ctrl_out.hum_avg_log2 = hum_avg_q[2] ? HUM_AVG_8 : hum_avg_q[1] ? HUM_AVG_4 :
                                 hum_avg_q[0] ? HUM_AVG_2 : HUM_AVG_1;
  assign ctrl_out.temp_avg_log2 = temperature_averaging_bit_q ? TEMP_AVG_16 : TEMP_AVG_8;

  sleep_halt_a: assert property (sleep |=> !sda_oe_out && st_q == ST_IDLE)
    else $error("bus active while asleep");
  variant_awake_a: assert property (var_lvl |-> !power_out.sleep)
    else $error("variant entered sleep");
  addr_reject_a: assert property (st_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE
    && sh_q[7:1] != TARGET_BUS_ADDRESS && !sleep && !start_cond && !stop_cond
    |=> st_q == ST_IDLE && !sda_oe_out)
    else $error("foreign address acknowledged");
  soft_rst_a: assert property (wr_stb && ptr_q == REG_SOFT_RESET && sh_q[SOFT_RESET_BIT]
    |=> soft_reset_out && hum_avg_q == HUM_AVG_RESET ##1 !soft_reset_out)
    else $error("soft reset action wrong");
  hum_avg_a: assert property (wr_stb && ptr_q == REG_MODE && sh_q[HUM_AVG_LSB + 2]
    |=> ctrl_out.hum_avg_log2 == HUM_AVG_8)
    else $error("humidity averaging decode wrong");
  temp_avg_a: assert property (wr_stb && ptr_q == REG_MODE && !sh_q[TEMP_AVG_BIT]
    |=> ctrl_out.temp_avg_log2 == TEMP_AVG_8)
    else $error("temperature averaging decode wrong");
  manual_start_a: assert property (wr_stb && ptr_q == REG_MODE && sh_q[MANUAL_BIT]
    && !sleep |=> ctrl_out.run)
    else $error("manual start lost");
  fault_set_a: assert property (result_in.fault |=> fault_q)
    else $error("fault event lost");
  fault_keep_a: assert property (fault_q && wr_stb && ptr_q == REG_FAULT
    && !sh_q[FAULT_BIT] |=> fault_q)
    else $error("fault cleared by zero write");
  ptr_write_a: assert property (wr_stb |=> ptr_q == 8'($past(ptr_q) + 8'h01))
    else $error("pointer did not advance on write");
  ptr_read_a: assert property (st_q == ST_TXACK && scl_rise && !sleep && !start_cond
    && !stop_cond |=> ptr_q == 8'($past(ptr_q) + 8'h01))
    else $error("pointer did not advance on read");
  manual_done_a: assert property (result_in.valid && !wr_stb
    |=> !manual_measurement_bit_q && humidity_result_q == $past(result_in.humidity_result))
    else $error("result update did not finish detection");
  ro_ignore_a: assert property (wr_stb && ptr_q == REG_CAP_LOW && !result_in.valid
    |=> $stable(cap_q))
    else $error("read-only register changed");

  write_seen_c: cover property (wr_stb && ptr_q == REG_MODE);
  read_byte_c: cover property (st_q == ST_TXACK && scl_rise && !sda_lvl);
  fault_seen_c: cover property (fault_q && wr_stb && ptr_q == REG_FAULT);
  soft_rst_c: cover property (soft_reset_out);
endmodule

// [design/htr_sync.sv]
// Purpose: Two-stage synchroniser with edge flags
// Assumes: Input is asynchronous to clk_in
// Notes: Edges are taken from the second and third stages only
`timescale 1ns/100ps
module htr_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // Start at the pin's idle level, no false edge
      meta_q <= IDLE_LEVEL;
      sync_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;
endmodule

// [testbench/htr_bus_master.sv]
// Purpose: Two-wire bus master model for register transfers
// Assumes: Open drain data line with pull-up, bus clock idles high
// Notes: Bus clock period 125 ns, still between frames
`timescale 1ns/100ps
module htr_bus_master (
  output logic scl_out,
  output logic sda_oe_out,
  input wire logic sda_in
);
  localparam real Q = 31.25;
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // Data moves a quarter period after the fall
  task automatic clk_bit(input logic b, output logic s);
    #(Q) sda_oe_out = !b;
    #(Q) scl_out = 1'b1;
    #(Q) s = sda_in;
    #(Q) scl_out = 1'b0;
  endtask
  task automatic start();
    if (!scl_out) begin
      #(Q) sda_oe_out = 1'b0;
      #(Q) scl_out = 1'b1;
    end
    #(2*Q) sda_oe_out = 1'b1;
    #(2*Q) scl_out = 1'b0;
  endtask
  task automatic stop();
    #(Q) sda_oe_out = 1'b1;
    #(Q) scl_out = 1'b1;
    #(2*Q) sda_oe_out = 1'b0;
    #(2*Q);
  endtask
  task automatic xbyte(input logic [7:0] b, input logic nak, output logic [7:0] r,
                       output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
      r[i] = s;
    end
    clk_bit(nak, s);
    ack = !s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d [16],
                    input int n, output logic ok);
    logic [7:0] r;
    logic k;
    start();
    xbyte({a, 1'b0}, 1'b1, r, ok);
    xbyte(p, 1'b1, r, k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      xbyte(d[i], 1'b1, r, k);
      ok &= k;
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                    output logic [7:0] d [16], output logic ok);
    logic [7:0] r;
    logic k;
    start();
    xbyte({a, 1'b0}, 1'b1, r, ok);
    xbyte(p, 1'b1, r, k);
    ok &= k;
    start();
    xbyte({a, 1'b1}, 1'b1, r, k);
    ok &= k;
    for (int i = 0; i < n; i++)
      xbyte(8'hff, i == n - 1, d[i], k);
    stop();
  endtask
endmodule

// [testbench/htr_sensor_regs_tb.sv]
// Purpose: Self-checking bench of the sensor register block
// Assumes: Bus master model on the two-wire port, results driven here
// Notes: Fixed seed, random values with corner cases
`timescale 1ns/100ps
module htr_sensor_regs_tb;
  import htr_pkg::*;
  logic clk_in, arst_n_in, ce, variant, scl, mst_oe, sda_out, sda_oe_out, soft_reset_out, ok;
  wire logic sda;
  htr_result_t result_in;
  htr_ctrl_t ctrl_out;
  htr_power_t power_out;
  int fails, tests_run, n0;
  int pulses = 0;
  logic [7:0] d [16];
  logic [7:0] q [16];
  logic [7:0] e [16];
  logic [7:0] v;
  logic [6:0] a;
  logic [15:0] x;
  assign sda = !((sda_oe_out && !sda_out) || mst_oe);
  htr_sensor_regs dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .chip_enable_in(ce),
    .power_control_variant_in(variant), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .result_in(result_in), .ctrl_out(ctrl_out),
    .power_out(power_out), .soft_reset_out(soft_reset_out));
  htr_bus_master m (.scl_out(scl), .sda_oe_out(mst_oe), .sda_in(sda));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (soft_reset_out === 1'b1) pulses <= pulses + 1;
  function automatic logic [1:0] hum_log2(input logic [2:0] f);
    casez (f)
      3'b000: return HUM_AVG_1;
      3'b001: return HUM_AVG_2;
      3'b01?: return HUM_AVG_4;
      default: return HUM_AVG_8;
    endcase
  endfunction
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] xe, input logic [7:0] g);
    tests_run++;
    if (g !== xe) begin
      $display("unexpected %s expected %h seen %h", n, xe, g);
      fails++;
    end
  endtask
  task automatic chk_port(input string n, input logic [15:0] xe, input logic [15:0] g);
    tests_run++;
    if (g !== xe) begin
      $display("unexpected %s expected %h seen %h", n, xe, g);
      fails++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr1(input logic [6:0] adr, input logic [7:0] p, input int n);
    m.wr(adr, p, d, n, ok);
    tick(3);
  endtask
  task automatic rdchk(input logic [7:0] p, input int n);
    m.rd(TARGET_BUS_ADDRESS, p, n, q, ok);
    tick(3);
    chk_port("read ack", 16'h0001, 16'(ok));
    for (int i = 0; i < n; i++)
      chk_reg($sformatf("reg %h", 8'(p + i)), e[i], q[i]);
  endtask
  task automatic pulse(input htr_result_t r);
    @(posedge clk_in);
    result_in <= r;
    @(posedge clk_in);
    result_in <= '0;
    tick(1);
  endtask
  initial begin
    #600000;
    fails++;
    wrap_up();
  end
  initial begin
    int seed;
    logic [9:0] h;
    logic [10:0] t;
    logic [15:0] c;
    arst_n_in = 1'b0;
    ce = 1'b1;
    variant = 1'b0;
    result_in = '0;
    fails = 0;
    tests_run = 0;
    seed = $urandom(81201);
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    tick(10);
    chk_port("power", 16'h000f, 16'(power_out));
    chk_port("ctrl", 16'h0003, 16'(ctrl_out));
    e = '{default: 8'h00};
    rdchk(REG_SOFT_RESET, 12);
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom);
      v[5:2] = 4'(i);
      v[0] = ~v[2];
      d[0] = v;
      wr1(TARGET_BUS_ADDRESS, REG_MODE, 1);
      x = 16'({v[0], hum_log2(v[5:3]), (v[2] ? TEMP_AVG_16 : TEMP_AVG_8)});
      chk_port("ctrl", x, 16'(ctrl_out));
      e[0] = v & 8'hfd;
      rdchk(REG_MODE, 1);
    end
    for (int k = 0; k < 2; k++) begin
      d[0] = 8'h01;
      wr1(TARGET_BUS_ADDRESS, REG_MODE, 1);
      chk_port("run", 16'h0001, 16'(ctrl_out.run));
      {h, t, c} = (k == 0) ? '1 : 37'({$urandom, $urandom});
      pulse('{valid: 1'b1, fault: 1'b0, humidity_result: h, temperature_result: t,
              capacitance: c});
      chk_port("run", 16'h0000, 16'(ctrl_out.run));
      e = '{default: 8'h00};
      e[3] = h[7:0];
      e[4] = 8'(h[9:8]);
      e[5] = t[7:0];
      e[6] = 8'(t[10:8]);
      e[9] = c[7:0];
      e[10] = c[15:8];
      rdchk(REG_MODE, 11);
      for (int j = 0; j < 8; j++) d[j] = 8'($urandom);
      wr1(TARGET_BUS_ADDRESS, REG_HUM_LOW, 8);
      for (int j = 0; j < 8; j++) e[j] = e[j + 3];
      rdchk(REG_HUM_LOW, 8);
    end
    pulse('{fault: 1'b1, default: '0});
    e[0] = 8'h01;
    rdchk(REG_FAULT, 1);
    d[0] = 8'hff;
    d[1] = 8'h00;
    wr1(TARGET_BUS_ADDRESS, 8'h02, 2);
    rdchk(REG_FAULT, 1);
    d[0] = 8'hff;
    wr1(TARGET_BUS_ADDRESS, REG_FAULT, 1);
    e[0] = 8'h00;
    rdchk(REG_FAULT, 1);
    d[0] = 8'h3d;
    wr1(TARGET_BUS_ADDRESS, REG_MODE, 1);
    pulse('{fault: 1'b1, default: '0});
    n0 = pulses;
    d[0] = 8'hfe;
    wr1(TARGET_BUS_ADDRESS, REG_SOFT_RESET, 1);
    chk_port("soft reset", 16'h0000, 16'(pulses - n0));
    e = '{default: 8'h00};
    e[1] = 8'h3d;
    e[3] = 8'h01;
    rdchk(REG_SOFT_RESET, 4);
    d[0] = 8'h01;
    wr1(TARGET_BUS_ADDRESS, REG_SOFT_RESET, 1);
    chk_port("soft reset", 16'h0001, 16'(pulses - n0));
    e = '{default: 8'h00};
    rdchk(REG_SOFT_RESET, 4);
    chk_port("ctrl", 16'h0003, 16'(ctrl_out));
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 7'h7e : 7'($urandom);
      if (a == TARGET_BUS_ADDRESS) a = 7'h00;
      d[0] = 8'h01;
      wr1(a, REG_MODE, 1);
      chk_port("nack", 16'h0000, 16'(ok));
      chk_port("run", 16'h0000, 16'(ctrl_out.run));
    end
    @(posedge clk_in);
    ce <= 1'b0;
    tick(4);
    chk_port("power", 16'h0010, 16'(power_out));
    wr1(TARGET_BUS_ADDRESS, REG_MODE, 1);
    chk_port("sleep ack", 16'h0000, 16'(ok));
    @(posedge clk_in);
    variant <= 1'b1;
    tick(4);
    chk_port("power", 16'h000f, 16'(power_out));
    wr1(TARGET_BUS_ADDRESS, REG_MODE, 1);
    chk_port("variant ack", 16'h0001, 16'(ok));
    chk_port("run", 16'h0001, 16'(ctrl_out.run));
    @(posedge clk_in);
    variant <= 1'b0;
    tick(4);
    chk_port("run", 16'h0000, 16'(ctrl_out.run));
    wrap_up();
  end
endmodule
